// ---- hw/bwd_watchdog.sv ----
// Purpose: Seconds-based board watchdog with sticky fired flag, IRQ slot select and board reset request
// Assumes: Host register port already decoded to two byte registers; one clock at 10 MHz
// Notes: Notes on behaviour list follows
`timescale 1ns/1ps
module bwd_watchdog #(
    parameter int unsigned TICK_CYCLES = bwd_pkg::TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEnable,
    input wire bwd_pkg::bwd_req_t req,
    output logic [7:0] readData,
    output logic [bwd_pkg::SERIRQ_SLOTS-1:0] irqRequest,
    output logic boardResetRequest,
    output logic watchdogFiredFlag
);
    localparam int CW = $clog2(TICK_CYCLES + 1);
    localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);

    bwd_pkg::bwd_ctrl_t ctrl;
    logic [7:0] seconds;
    logic [CW-1:0] prescale;
    logic tick;
    logic fireNow;
    logic wrControl;
    logic wrSeconds;
    logic [7:0] next_seconds;
    logic clearFired;

    function automatic logic [3:0] slotOf(input logic [2:0] s);
        case (s)
            3'h0: slotOf = bwd_pkg::IRQ3;
            3'h1: slotOf = bwd_pkg::IRQ4;
            3'h2: slotOf = bwd_pkg::IRQ5;
            3'h3: slotOf = bwd_pkg::IRQ10;
            3'h4: slotOf = bwd_pkg::IRQ6;
            3'h5: slotOf = bwd_pkg::IRQ7;
            3'h6: slotOf = bwd_pkg::IRQ9;
            default: slotOf = bwd_pkg::IRQ11;
        endcase
    endfunction

    assign wrControl = req.wr && req.sel == bwd_pkg::SEL_CONTROL;
    assign wrSeconds = req.wr && req.sel == bwd_pkg::SEL_SECONDS;
    assign tick = prescale == TICK_LAST;
    assign fireNow = ctrl.watchdogRun && seconds == 8'h00;
    assign clearFired = wrSeconds || (wrControl && !req.data[bwd_pkg::RUN_BIT]);

    // Prescaler runs free so the first second after a reload can be short
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            prescale <= '0;
        else if (clkEnable)
        begin
            if (tick)
                prescale <= '0;
            else
                prescale <= prescale + CW'(1);
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl.interruptEnable <= 1'b0;
            ctrl.irqLineSelect <= bwd_pkg::IRQ_SEL_RESET;
            ctrl.boardRestartAllow <= 1'b0;
            ctrl.watchdogRun <= 1'b0;
        end
        else if (clkEnable && wrControl)
        begin
            ctrl.interruptEnable <= req.data[bwd_pkg::IRQ_EN_BIT];
            ctrl.irqLineSelect <= req.data[bwd_pkg::IRQ_SEL_HI:bwd_pkg::IRQ_SEL_LO];
            ctrl.boardRestartAllow <= req.data[bwd_pkg::BOARD_RST_BIT];
            ctrl.watchdogRun <= req.data[bwd_pkg::RUN_BIT];
        end
    end

    always_comb
    begin
        next_seconds = seconds;
        if (wrSeconds)
            next_seconds = req.data;
        else if (ctrl.watchdogRun && tick && seconds != 8'h00)
            next_seconds = seconds - 8'h01;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            seconds <= bwd_pkg::SECONDS_RESET;
        else if (clkEnable)
            seconds <= next_seconds;
    end

    // Firing wins over a same-cycle clear so no expiry is lost
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            watchdogFiredFlag <= 1'b0;
        else if (clkEnable)
        begin
            if (fireNow)
                watchdogFiredFlag <= 1'b1;
            else if (clearFired)
                watchdogFiredFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            boardResetRequest <= 1'b0;
        else if (clkEnable)
            boardResetRequest <= watchdogFiredFlag && ctrl.boardRestartAllow;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            irqRequest <= '0;
        else if (clkEnable)
        begin
            irqRequest <= '0;
            if (watchdogFiredFlag && ctrl.interruptEnable)
                irqRequest[slotOf(ctrl.irqLineSelect)] <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            readData <= '0;
        else if (clkEnable && req.rd)
        begin
            if (req.sel == bwd_pkg::SEL_SECONDS)
                readData <= seconds;
            else
                readData <= {ctrl.interruptEnable, ctrl.irqLineSelect, 1'b0,
                    ctrl.boardRestartAllow, ctrl.watchdogRun, watchdogFiredFlag};
        end
    end

    fired_sticky_a: assert property (@(posedge clk) disable iff (reset)
        clkEnable && watchdogFiredFlag && !wrSeconds && !wrControl |=> watchdogFiredFlag)
        else $error("Fired flag dropped without a clearing event");
    fire_zero_a: assert property (@(posedge clk) disable iff (reset)
        clkEnable && fireNow |=> watchdogFiredFlag)
        else $error("Zero timeout with run set did not fire");
    no_fire_off_a: assert property (@(posedge clk) disable iff (reset)
        clkEnable && !ctrl.watchdogRun && !watchdogFiredFlag |=> !watchdogFiredFlag)
        else $error("Fired while run was clear");
    reload_a: assert property (@(posedge clk) disable iff (reset)
        clkEnable && wrSeconds |=> seconds == $past(req.data))
        else $error("Seconds write did not reload");
    count_down_a: assert property (@(posedge clk) disable iff (reset)
        clkEnable && !wrSeconds && ctrl.watchdogRun && tick && seconds != 8'h00 |=> seconds == $past(seconds) - 8'h01)
        else $error("Seconds did not decrement on tick");
    hold_off_a: assert property (@(posedge clk) disable iff (reset)
        clkEnable && !wrSeconds && !ctrl.watchdogRun |=> $stable(seconds))
        else $error("Seconds changed while stopped");
    board_rst_a: assert property (@(posedge clk) disable iff (reset)
        clkEnable && !ctrl.boardRestartAllow |=> !boardResetRequest)
        else $error("Board reset without permission");
    irq_gate_a: assert property (@(posedge clk) disable iff (reset)
        clkEnable && !(watchdogFiredFlag && ctrl.interruptEnable) |=> irqRequest == '0)
        else $error("Interrupt raised while gated");
    irq_slot_a: assert property (@(posedge clk) disable iff (reset)
        clkEnable && watchdogFiredFlag && ctrl.interruptEnable |=> irqRequest[slotOf($past(ctrl.irqLineSelect))])
        else $error("Interrupt missing on selected slot");
    reserved_a: assert property (@(posedge clk) disable iff (reset)
        clkEnable && req.rd && req.sel == bwd_pkg::SEL_CONTROL |=> !readData[bwd_pkg::RESERVED_BIT])
        else $error("Reserved bit read non-zero");
    tick_period_a: assert property (@(posedge clk) disable iff (reset)
        clkEnable && tick |=> prescale == '0)
        else $error("Prescaler did not wrap");

    // Assertion helper: ticks seen since the last reload, to hold expiry against the loaded count
    // Saturates instead of wrapping, so a long run at zero cannot alias back to a live count
    logic [7:0] ticksSinceLoad;
    logic [7:0] lastLoad;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ticksSinceLoad <= '0;
            lastLoad <= bwd_pkg::SECONDS_RESET;
        end
        else if (clkEnable)
        begin
            if (wrSeconds)
            begin
                ticksSinceLoad <= '0;
                lastLoad <= req.data;
            end
            else if (ctrl.watchdogRun && tick && ticksSinceLoad != 8'hFF)
                ticksSinceLoad <= ticksSinceLoad + 8'h01;
        end
    end

    // Expiry path: zero count with run set, then the flag, then the outputs
    // Every step needs the clock enable, since a frozen cycle moves nothing
    sequence expiry_s;
        clkEnable && fireNow;
    endsequence

    sequence resetArmed_s;
        clkEnable && watchdogFiredFlag && ctrl.boardRestartAllow;
    endsequence

    sequence irqArmed_s;
        clkEnable && watchdogFiredFlag && ctrl.interruptEnable;
    endsequence

    sequence readControl_s;
        clkEnable && req.rd && req.sel == bwd_pkg::SEL_CONTROL;
    endsequence

    sequence readSeconds_s;
        clkEnable && req.rd && req.sel == bwd_pkg::SEL_SECONDS;
    endsequence

    expiry_reset_a: assert property (@(posedge clk) disable iff (reset)
        expiry_s ##1 resetArmed_s |=> boardResetRequest)
        else $error("Expiry did not request a board reset");

    expiry_irq_a: assert property (@(posedge clk) disable iff (reset)
        expiry_s ##1 irqArmed_s |=> irqRequest[slotOf($past(ctrl.irqLineSelect))])
        else $error("Expiry did not raise the selected interrupt");

    board_rst_on_a: assert property (@(posedge clk) disable iff (reset)
        resetArmed_s |=> boardResetRequest)
        else $error("Fired with restart allowed but no board reset");

    stopped_quiet_a: assert property (@(posedge clk) disable iff (reset)
        clkEnable && !ctrl.watchdogRun && !watchdogFiredFlag |=> !boardResetRequest)
        else $error("Board reset while stopped and not fired");

    irq_onehot_a: assert property (@(posedge clk) disable iff (reset)
        $onehot0(irqRequest))
        else $error("More than one interrupt slot driven");

    // Count and reload agree: zero exactly when the loaded number of ticks has passed
    expiry_time_a: assert property (@(posedge clk) disable iff (reset)
        (seconds == 8'h00) == (ticksSinceLoad >= lastLoad))
        else $error("Expiry time does not match the loaded count");

    seconds_floor_a: assert property (@(posedge clk) disable iff (reset)
        clkEnable && !wrSeconds && seconds == 8'h00 |=> seconds == 8'h00)
        else $error("Seconds moved below zero");

    fired_clear_a: assert property (@(posedge clk) disable iff (reset)
        clkEnable && clearFired && !fireNow |=> !watchdogFiredFlag)
        else $error("Clearing event left the fired flag set");

    ctrl_write_a: assert property (@(posedge clk) disable iff (reset)
        clkEnable && wrControl |=> ctrl.interruptEnable == $past(req.data[bwd_pkg::IRQ_EN_BIT])
            && ctrl.watchdogRun == $past(req.data[bwd_pkg::RUN_BIT])
            && ctrl.boardRestartAllow == $past(req.data[bwd_pkg::BOARD_RST_BIT]))
        else $error("Control write did not land");

    // Read data is registered, so it answers one edge after the request
    read_seconds_a: assert property (@(posedge clk) disable iff (reset)
        readSeconds_s |=> readData == $past(seconds))
        else $error("Seconds read returned a stale value");

    read_status_a: assert property (@(posedge clk) disable iff (reset)
        readControl_s |=> readData[bwd_pkg::FIRED_BIT] == $past(watchdogFiredFlag)
            && readData[bwd_pkg::RUN_BIT] == $past(ctrl.watchdogRun)
            && readData[bwd_pkg::IRQ_SEL_HI:bwd_pkg::IRQ_SEL_LO] == $past(ctrl.irqLineSelect))
        else $error("Control read did not return the live settings");

    tick_range_a: assert property (@(posedge clk) disable iff (reset)
        prescale <= TICK_LAST)
        else $error("Prescaler ran past its last count");

    // While the enable is low nothing may move, the prescaler included
    freeze_state_a: assert property (@(posedge clk) disable iff (reset)
        !clkEnable |=> $stable(seconds) && $stable(prescale) && $stable(ctrl) && $stable(watchdogFiredFlag))
        else $error("State moved while the clock enable was low");

    freeze_outputs_a: assert property (@(posedge clk) disable iff (reset)
        !clkEnable |=> $stable(readData) && $stable(irqRequest) && $stable(boardResetRequest))
        else $error("Outputs moved while the clock enable was low");
endmodule // bwd_watchdog

// ---- hw/bwd_pkg.sv ----
// Purpose: Shared constants and types for the board watchdog timer
// Assumes: 10 MHz system clock, byte-wide register port
// Notes: Register selects are local to this block's own decode
package bwd_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned TICK_PERIOD_S = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
    localparam logic [0:0] SEL_CONTROL = 1'h0;
    localparam logic [0:0] SEL_SECONDS = 1'h1;
    localparam int IRQ_EN_BIT = 7;
    localparam int IRQ_SEL_HI = 6;
    localparam int IRQ_SEL_LO = 4;
    localparam int RESERVED_BIT = 3;
    localparam int BOARD_RST_BIT = 2;
    localparam int RUN_BIT = 1;
    localparam int FIRED_BIT = 0;
    localparam logic [7:0] SECONDS_RESET = 8'h00;
    localparam logic [2:0] IRQ_SEL_RESET = 3'h0;
    localparam int SERIRQ_SLOTS = 16;
    localparam logic [3:0] IRQ3 = 4'h3;
    localparam logic [3:0] IRQ4 = 4'h4;
    localparam logic [3:0] IRQ5 = 4'h5;
    localparam logic [3:0] IRQ6 = 4'h6;
    localparam logic [3:0] IRQ7 = 4'h7;
    localparam logic [3:0] IRQ9 = 4'h9;
    localparam logic [3:0] IRQ10 = 4'hA;
    localparam logic [3:0] IRQ11 = 4'hB;

    typedef struct packed {
        logic interruptEnable;
        logic [2:0] irqLineSelect;
        logic boardRestartAllow;
        logic watchdogRun;
    } bwd_ctrl_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [0:0] sel;
        logic [7:0] data;
    } bwd_req_t;
endpackage

// ---- test/bwd_host_model.sv ----
// Purpose: Host-side receiver for the watchdog interrupt and board reset lines
// Assumes: One-hot level interrupt requests indexed by IRQ number
// Notes: Reports the highest active slot, 0 when no request stands
`timescale 1ns/1ps
module bwd_host_model
(
    input wire logic [15:0] irqRequest,
    input wire logic boardResetRequest,
    output logic [4:0] irqNumber,
    output int resetCount
);
    always_comb
    begin
        irqNumber = 5'h00;
        for (int i = 0; i < 16; i++)
            if (irqRequest[i]) irqNumber = 5'(i);
    end
    // Counts press events, so a request that never drops is seen once only
    initial
    begin
        resetCount = 0;
        forever
        begin
            @(posedge boardResetRequest);
            resetCount++;
        end
    end
endmodule // bwd_host_model

// ---- test/tb.sv ----
// Purpose: Self-checking bench for the board watchdog timer
// Assumes: Short prescaler of 20 cycles so one second is 20 clocks
// Notes: Register requests launched on the falling edge
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic clkEnable = 1'h1;
    bwd_pkg::bwd_req_t req = '0;
    logic [7:0] readData;
    logic [15:0] irqRequest;
    logic boardResetRequest;
    logic watchdogFiredFlag;
    logic [4:0] irqNumber;
    int resetCount;
    int fails = 0;
    int samples_checked = 0;
    logic [7:0] v;
    logic [3:0] slotOf [8] = '{4'h3, 4'h4, 4'h5, 4'hA, 4'h6, 4'h7, 4'h9, 4'hB};
    bwd_watchdog #(.TICK_CYCLES(20)) bwd_watchdog_inst (.clk(clk), .reset(reset), .clkEnable(clkEnable),
        .req(req), .readData(readData), .irqRequest(irqRequest),
        .boardResetRequest(boardResetRequest), .watchdogFiredFlag(watchdogFiredFlag));
    bwd_host_model bwd_host_model_inst (.irqRequest(irqRequest), .boardResetRequest(boardResetRequest),
        .irqNumber(irqNumber), .resetCount(resetCount));
    initial forever #50 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic sel, input logic [7:0] d);
        @(negedge clk);
        req <= {1'b1, 1'b0, sel, d};
        @(negedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic sel, output logic [7:0] d);
        @(negedge clk);
        req <= {1'b0, 1'b1, sel, 8'h00};
        @(negedge clk);
        req <= '0;
        @(negedge clk);
        d = readData;
    endtask
    task automatic summarize;
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Whole run is under 600 clocks, so 1 ms only trips on a hang
    initial
    begin
        #1ms;
        fails++;
        summarize;
    end
    initial
    begin
        cyc(6);
        reset <= 1'b0;
        rd(1'b0, v);
        chk("ctrl reset", 8'h00, v);
        rd(1'b1, v);
        chk("seconds reset", 8'h00, v);
        wr(1'b1, 8'h05);
        wr(1'b0, 8'h0E);
        rd(1'b0, v);
        chk("ctrl readback", 8'h06, v);
        repeat (3)
        begin
            cyc(60);
            wr(1'b1, 8'h05);
        end
        chk("kicked flag", 1'b0, watchdogFiredFlag);
        cyc(70);
        chk("early flag", 1'b0, watchdogFiredFlag);
        cyc(35);
        chk("fired flag", 1'b1, watchdogFiredFlag);
        chk("board reset", 1'b1, boardResetRequest);
        chk("reset count", 16'h0001, 16'(resetCount));
        rd(1'b0, v);
        chk("ctrl fired", 8'h07, v);
        cyc(10);
        chk("sticky flag", 1'b1, watchdogFiredFlag);
        // First stop write races the firing condition, the second one clears
        wr(1'b0, 8'h04);
        wr(1'b0, 8'h04);
        cyc(2);
        chk("stop clears flag", 1'b0, watchdogFiredFlag);
        chk("board reset off", 1'b0, boardResetRequest);
        wr(1'b1, 8'h02);
        cyc(60);
        rd(1'b1, v);
        chk("frozen seconds", 8'h02, v);
        chk("stopped flag", 1'b0, watchdogFiredFlag);
        wr(1'b1, 8'h00);
        for (int k = 0; k < 8; k++)
        begin
            wr(1'b0, {1'b1, 3'(k), 4'h2});
            cyc(3);
            chk("irq slot", 16'h0001 << slotOf[k], irqRequest);
            chk("irq number", 16'(slotOf[k]), 16'(irqNumber));
        end
        chk("no board reset", 1'b0, boardResetRequest);
        wr(1'b0, 8'h72);
        cyc(3);
        chk("irq masked", 16'h0000, irqRequest);
        // First reload races the standing expiry, the second clears the flag
        wr(1'b1, 8'h03);
        wr(1'b1, 8'h03);
        // Frozen for five seconds' worth of clocks: no count, no fire
        clkEnable <= 1'h0;
        cyc(100);
        clkEnable <= 1'h1;
        chk("frozen flag", 1'b0, watchdogFiredFlag);
        // The tick that fell due as the freeze began lands on the first enabled edge
        rd(1'b1, v);
        chk("frozen count", 8'h02, v);
        wr(1'b1, 8'h09);
        reset <= 1'b1;
        cyc(2);
        reset <= 1'b0;
        rd(1'b0, v);
        chk("ctrl after reset", 8'h00, v);
        rd(1'b1, v);
        chk("seconds after reset", 8'h00, v);
        chk("irq after reset", 16'h0000, irqRequest);
        summarize;
    end
endmodule // tb
